// ---- hw/hds_pkg.sv ----
// Constants, types and register map of the hysteresis digital I/O sampler
// ----------------------------------------------------------------------
// Summary of operation
// R1: Twelve inputs and twelve outputs, fixed direction, nothing configurable.
// R2: Output one turns high-side switch on; zero leaves output floating.
// R3: Hold lower and upper threshold codes; select one at a time.
// R4: Each cycle first capture comparators with lower threshold selected.
// R5: Then select upper threshold and capture comparators again.
// R6: Lines whose two captures agree take the second capture.
// R7: Lines whose captures differ keep their stored state.
// R8: Two-capture cycle repeats continuously at one million per second.
// R9: Each threshold code is ten bits unsigned, 0 to 1023.
// R10: Software keeps upper code at least fifty above lower code.
// R11: Reset values: lower threshold 0, upper threshold 300.
// R12: Sampled input words buffered in a 512-entry input queue.
// R13: Output words buffered in a 1024-entry output queue.
// R14: Input transfers and output updates paced at 100 kS/s.
// R15: Flag change of state when any stored input changes.
// R16: After reset stored inputs and all outputs are zero.
// R17: Sample into full input queue sets sticky error, sample dropped.
// ----------------------------------------------------------------------
package hds_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int N_IN = 12;
  localparam int N_OUT = 12;
  localparam int THR_W = 10;
  localparam int IN_DEPTH = 512;
  localparam int IN_AW = 9;
  localparam int OUT_DEPTH = 1024;
  localparam int OUT_AW = 10;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int CYCLE_PERIOD_NS = 1000;
  localparam int XFER_PERIOD_NS = 10000;
  localparam int CYCLE_CLKS = CYCLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PHASE_CLKS = CYCLE_CLKS / 2;
  localparam int XFER_CLKS = XFER_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [4:0] PHASE_LAST = 5'(PHASE_CLKS - 1);
  localparam logic [7:0] XFER_LAST = 8'(XFER_CLKS - 1);

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [THR_W-1:0] THR_LO_RST = 10'h000;
  localparam logic [THR_W-1:0] THR_HI_RST = 10'h12C;

  // ----------------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_THR_LO = 8'h04;
  localparam logic [ADDR_W-1:0] A_THR_HI = 8'h08;
  localparam logic [ADDR_W-1:0] A_IN_STATE = 8'h0C;
  localparam logic [ADDR_W-1:0] A_IN_DATA = 8'h10;
  localparam logic [ADDR_W-1:0] A_OUT_DATA = 8'h14;
  localparam logic [ADDR_W-1:0] A_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] A_MASK = 8'h1C;
  localparam logic [ADDR_W-1:0] A_LEVEL = 8'h20;

  localparam int CTRL_SMP_EN_BIT = 0;
  localparam int CTRL_OUT_EN_BIT = 1;
  localparam int LEVEL_OUT_LSB = 16;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic out_ovf;
    logic in_ovf;
    logic cos;
  } hds_evt_t;

  typedef struct packed {
    logic [THR_W-1:0] hi;
    logic [THR_W-1:0] lo;
  } hds_thr_t;

  typedef enum logic [1:0] {
    PH_LOW = 2'b01,
    PH_HIGH = 2'b10
  } hds_phase_t;

endpackage : hds_pkg

// ---- hw/hds_mem.sv ----
// Single-port-write, registered-read word memory for the sampler queues
`timescale 1ns/100ps

module hds_mem #(
  parameter int W = 12,
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Read side
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Read data from a register so it maps to block RAM
  always_ff @(posedge clk)
  begin
    rdata <= mem[raddr];
  end

endmodule : hds_mem

// ---- hw/hds_dio_top.sv ----
// Hysteresis input sampler, queued outputs and register port
`timescale 1ns/100ps

module hds_dio_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Register port
  input wire logic [hds_pkg::ADDR_W-1:0] ADDR,
  input wire logic [hds_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [hds_pkg::DATA_W-1:0] RDATA,
  // Comparators and threshold converters
  input wire logic [hds_pkg::N_IN-1:0] CMP_IN,
  output hds_pkg::hds_thr_t THR_CODE,
  output logic THR_SEL_HIGH,
  // High-side switches
  output logic [hds_pkg::N_OUT-1:0] DO_ON,
  // Interrupt
  output logic IRQ
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [hds_pkg::N_IN-1:0] cmp_meta_r;
  logic [hds_pkg::N_IN-1:0] cmp_sync_r;
  logic [hds_pkg::N_IN-1:0] cap_lo_r;
  logic [hds_pkg::N_IN-1:0] state_r;
  logic [hds_pkg::N_IN-1:0] state_nxt;
  logic [hds_pkg::N_IN-1:0] agree;
  hds_pkg::hds_phase_t phase_r;
  logic [4:0] ph_cnt_r;
  logic cycle_done;
  logic [7:0] xfer_cnt_r;
  logic xfer_tick;
  hds_pkg::hds_thr_t thr_r;
  logic smp_en_r;
  logic out_en_r;
  hds_pkg::hds_evt_t status_r;
  hds_pkg::hds_evt_t status_nxt;
  hds_pkg::hds_evt_t mask_r;
  hds_pkg::hds_evt_t evt_set;
  hds_pkg::hds_evt_t evt_clr;
  logic [hds_pkg::IN_AW-1:0] in_wp_r;
  logic [hds_pkg::IN_AW-1:0] in_rp_r;
  logic [hds_pkg::IN_AW:0] in_cnt_r;
  logic in_full;
  logic in_empty;
  logic in_push;
  logic in_pop;
  logic [hds_pkg::N_IN-1:0] in_q;
  logic [hds_pkg::OUT_AW-1:0] out_wp_r;
  logic [hds_pkg::OUT_AW-1:0] out_rp_r;
  logic [hds_pkg::OUT_AW:0] out_cnt_r;
  logic out_full;
  logic out_empty;
  logic out_push;
  logic out_pop;
  logic out_apply_r;
  logic [hds_pkg::N_OUT-1:0] out_q;
  logic [hds_pkg::N_OUT-1:0] do_r;
  logic wr_ctrl;
  logic wr_thr_lo;
  logic wr_thr_hi;
  logic wr_out;
  logic wr_status;
  logic wr_mask;
  logic rd_in;
  logic [hds_pkg::DATA_W-1:0] rdata_r;
  logic [hds_pkg::DATA_W-1:0] rdata_nxt;
  logic in_sel_r;

  // ----------------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      cmp_meta_r <= '0;
      cmp_sync_r <= '0;
    end
    else
    begin
      cmp_meta_r <= CMP_IN;
      cmp_sync_r <= cmp_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // Threshold phase sequencer
  // ----------------------------------------------------------------------
  // Capture at the last clock of each phase; the two synchroniser stages
  // and comparator settling both fit well inside a ten-clock phase.
  // R8: continuous 1 MHz cycle
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ph_cnt_r <= '0;
      phase_r <= hds_pkg::PH_LOW;
    end
    else if (ph_cnt_r == hds_pkg::PHASE_LAST)
    begin
      ph_cnt_r <= '0;
      case (phase_r)
        hds_pkg::PH_LOW: phase_r <= hds_pkg::PH_HIGH;
        hds_pkg::PH_HIGH: phase_r <= hds_pkg::PH_LOW;
        default: phase_r <= hds_pkg::PH_LOW;
      endcase
    end
    else
    begin
      ph_cnt_r <= ph_cnt_r + 5'h01;
    end
  end

  assign cycle_done = (ph_cnt_r == hds_pkg::PHASE_LAST) && (phase_r == hds_pkg::PH_HIGH);
  // R3: one threshold routed at a time
  assign THR_SEL_HIGH = (phase_r == hds_pkg::PH_HIGH);
  assign THR_CODE = thr_r;

  // R4: lower-threshold capture
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      cap_lo_r <= '0;
    end
    else if ((ph_cnt_r == hds_pkg::PHASE_LAST) && (phase_r == hds_pkg::PH_LOW))
    begin
      cap_lo_r <= cmp_sync_r;
    end
  end

  // R5: second capture is the live upper-threshold read
  assign agree = ~(cap_lo_r ^ cmp_sync_r);

  // R6: agreeing lines take the second read
  // R7: disagreeing lines hold
  assign state_nxt = (agree & cmp_sync_r) | (~agree & state_r);

  // R16: inputs start at zero
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      state_r <= '0;
    end
    else if (cycle_done)
    begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Transfer pacing
  // ----------------------------------------------------------------------
  // R14: 100 kS/s tick
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      xfer_cnt_r <= '0;
    end
    else if (xfer_tick)
    begin
      xfer_cnt_r <= '0;
    end
    else
    begin
      xfer_cnt_r <= xfer_cnt_r + 8'h01;
    end
  end

  assign xfer_tick = (xfer_cnt_r == hds_pkg::XFER_LAST);

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    wr_ctrl = 1'b0;
    wr_thr_lo = 1'b0;
    wr_thr_hi = 1'b0;
    wr_out = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    if (ADDR == hds_pkg::A_CTRL)
      wr_ctrl = WR;
    else if (ADDR == hds_pkg::A_THR_LO)
      wr_thr_lo = WR;
    else if (ADDR == hds_pkg::A_THR_HI)
      wr_thr_hi = WR;
    else if (ADDR == hds_pkg::A_OUT_DATA)
      wr_out = WR;
    else if (ADDR == hds_pkg::A_STATUS)
      wr_status = WR;
    else if (ADDR == hds_pkg::A_MASK)
      wr_mask = WR;
  end

  assign rd_in = RD && (ADDR == hds_pkg::A_IN_DATA);

  // R9: ten-bit codes
  // R11: threshold defaults
  // Upper-above-lower spacing is software's job and is not enforced here
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      thr_r.lo <= hds_pkg::THR_LO_RST;
      thr_r.hi <= hds_pkg::THR_HI_RST;
    end
    else
    begin
      if (wr_thr_lo)
        thr_r.lo <= WDATA[hds_pkg::THR_W-1:0];
      if (wr_thr_hi)
        thr_r.hi <= WDATA[hds_pkg::THR_W-1:0];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      smp_en_r <= 1'b0;
      out_en_r <= 1'b0;
      mask_r <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        smp_en_r <= WDATA[hds_pkg::CTRL_SMP_EN_BIT];
        out_en_r <= WDATA[hds_pkg::CTRL_OUT_EN_BIT];
      end
      if (wr_mask)
        mask_r <= hds_pkg::hds_evt_t'(WDATA[2:0]);
    end
  end

  // ----------------------------------------------------------------------
  // Input queue
  // ----------------------------------------------------------------------
  assign in_full = (in_cnt_r == (hds_pkg::IN_AW+1)'(hds_pkg::IN_DEPTH));
  assign in_empty = (in_cnt_r == '0);
  // R17: full queue drops the sample
  assign in_push = xfer_tick && smp_en_r && !in_full;
  assign in_pop = rd_in && !in_empty;

  // R12: 512-entry input queue
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      in_wp_r <= '0;
      in_rp_r <= '0;
      in_cnt_r <= '0;
    end
    else
    begin
      if (in_push)
        in_wp_r <= in_wp_r + (hds_pkg::IN_AW)'(1'b1);
      if (in_pop)
        in_rp_r <= in_rp_r + (hds_pkg::IN_AW)'(1'b1);
      if (in_push && !in_pop)
        in_cnt_r <= in_cnt_r + (hds_pkg::IN_AW+1)'(1'b1);
      else if (in_pop && !in_push)
        in_cnt_r <= in_cnt_r - (hds_pkg::IN_AW+1)'(1'b1);
    end
  end

  hds_mem #(
    .W(hds_pkg::N_IN),
    .DEPTH(hds_pkg::IN_DEPTH),
    .AW(hds_pkg::IN_AW)
  ) u_in_mem (
    .clk(CLK),
    .we(in_push),
    .waddr(in_wp_r),
    .wdata(state_r),
    .raddr(in_rp_r),
    .rdata(in_q)
  );

  // ----------------------------------------------------------------------
  // Output queue
  // ----------------------------------------------------------------------
  assign out_full = (out_cnt_r == (hds_pkg::OUT_AW+1)'(hds_pkg::OUT_DEPTH));
  assign out_empty = (out_cnt_r == '0);
  assign out_push = wr_out && !out_full;
  assign out_pop = xfer_tick && out_en_r && !out_empty;

  // R13: 1024-entry output queue
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      out_wp_r <= '0;
      out_rp_r <= '0;
      out_cnt_r <= '0;
      out_apply_r <= 1'b0;
    end
    else
    begin
      out_apply_r <= out_pop;
      if (out_push)
        out_wp_r <= out_wp_r + (hds_pkg::OUT_AW)'(1'b1);
      if (out_pop)
        out_rp_r <= out_rp_r + (hds_pkg::OUT_AW)'(1'b1);
      if (out_push && !out_pop)
        out_cnt_r <= out_cnt_r + (hds_pkg::OUT_AW+1)'(1'b1);
      else if (out_pop && !out_push)
        out_cnt_r <= out_cnt_r - (hds_pkg::OUT_AW+1)'(1'b1);
    end
  end

  hds_mem #(
    .W(hds_pkg::N_OUT),
    .DEPTH(hds_pkg::OUT_DEPTH),
    .AW(hds_pkg::OUT_AW)
  ) u_out_mem (
    .clk(CLK),
    .we(out_push),
    .waddr(out_wp_r),
    .wdata(WDATA[hds_pkg::N_OUT-1:0]),
    .raddr(out_rp_r),
    .rdata(out_q)
  );

  // R16: outputs off after reset
  // R2: one drives the switch, zero floats
  always_ff @(posedge CLK)
  begin
    if (RESET)
      do_r <= '0;
    else if (out_apply_r)
      do_r <= out_q;
  end

  // R1: fixed twelve-in, twelve-out
  assign DO_ON = do_r;

  // ----------------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------------
  always_comb
  begin
    evt_set = '0;
    // R15: change of state
    evt_set.cos = cycle_done && (state_nxt != state_r);
    // R17: overflow flag
    evt_set.in_ovf = xfer_tick && smp_en_r && in_full;
    evt_set.out_ovf = wr_out && out_full;
    evt_clr = wr_status ? hds_pkg::hds_evt_t'(WDATA[2:0]) : '0;
    // A new event outranks a clear in the same cycle
    status_nxt = (status_r & ~evt_clr) | evt_set;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      status_r <= '0;
    else
      status_r <= status_nxt;
  end

  assign IRQ = |(status_r & mask_r);

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = '0;
    if (ADDR == hds_pkg::A_CTRL)
    begin
      rdata_nxt[hds_pkg::CTRL_SMP_EN_BIT] = smp_en_r;
      rdata_nxt[hds_pkg::CTRL_OUT_EN_BIT] = out_en_r;
    end
    else if (ADDR == hds_pkg::A_THR_LO)
      rdata_nxt[hds_pkg::THR_W-1:0] = thr_r.lo;
    else if (ADDR == hds_pkg::A_THR_HI)
      rdata_nxt[hds_pkg::THR_W-1:0] = thr_r.hi;
    else if (ADDR == hds_pkg::A_IN_STATE)
      rdata_nxt[hds_pkg::N_IN-1:0] = state_r;
    else if (ADDR == hds_pkg::A_OUT_DATA)
      rdata_nxt[hds_pkg::N_OUT-1:0] = do_r;
    else if (ADDR == hds_pkg::A_STATUS)
      rdata_nxt[2:0] = status_r;
    else if (ADDR == hds_pkg::A_MASK)
      rdata_nxt[2:0] = mask_r;
    else if (ADDR == hds_pkg::A_LEVEL)
    begin
      rdata_nxt[hds_pkg::IN_AW:0] = in_cnt_r;
      rdata_nxt[hds_pkg::LEVEL_OUT_LSB +: hds_pkg::OUT_AW+1] = out_cnt_r;
    end
  end

  // Queue data comes straight from the memory register; an empty read gives zero
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      rdata_r <= '0;
      in_sel_r <= 1'b0;
    end
    else
    begin
      rdata_r <= RD ? rdata_nxt : '0;
      in_sel_r <= in_pop;
    end
  end

  assign RDATA = in_sel_r ? {{(hds_pkg::DATA_W-hds_pkg::N_IN){1'b0}}, in_q} : rdata_r;

endmodule : hds_dio_top

// ---- sim/hds_field_model.sv ----
// Comparator bank model standing for the field inputs
`timescale 1ns/100ps

module hds_field_model (
  // Threshold converters
  input wire hds_pkg::hds_thr_t thr_code,
  input wire logic thr_sel_high,
  // Field voltages as converter codes
  input wire logic [11:0][9:0] level,
  // Comparator outputs
  output logic [11:0] cmp_out
);
  logic [9:0] ref_code;

  assign ref_code = thr_sel_high ? thr_code.hi : thr_code.lo;

  // Zero settling time; a level between the codes flips with the select
  always_comb
  begin
    for (int i = 0; i < 12; i++)
    begin
      cmp_out[i] = level[i] > ref_code;
    end
  end
endmodule : hds_field_model

// ---- sim/hds_dio_checker.sv ----
// Port assertions for the hysteresis digital I/O top
`timescale 1ns/100ps

module hds_dio_checker (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // Field side
  input wire logic [11:0] CMP_IN,
  input wire hds_pkg::hds_thr_t THR_CODE,
  input wire logic THR_SEL_HIGH,
  input wire logic [11:0] DO_ON,
  input wire logic IRQ
);
  logic [9:0] hi_q;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  always_ff @(posedge CLK)
  begin
    hi_q <= THR_CODE.hi;
  end

  // ------
  // Sampler phases
  // ------
  upper_phase_a: assert property (
    $rose(THR_SEL_HIGH) |-> THR_SEL_HIGH[*8] ##1 THR_SEL_HIGH ##1 THR_SEL_HIGH ##1 !THR_SEL_HIGH)
    else $error("upper phase not ten clocks");
  lower_phase_a: assert property (
    $fell(THR_SEL_HIGH) |-> !THR_SEL_HIGH[*8] ##1 !THR_SEL_HIGH ##1 !THR_SEL_HIGH ##1 THR_SEL_HIGH)
    else $error("lower phase not ten clocks");

  // ------
  // Thresholds and outputs
  // ------
  lo_write_a: assert property (
    WR && ADDR == hds_pkg::A_THR_LO |=> {22'h0, THR_CODE.lo} == ($past(WDATA) & 32'h0000_03FF))
    else $error("lower code not written");
  hi_write_a: assert property (
    WR && ADDR == hds_pkg::A_THR_HI |=> {22'h0, THR_CODE.hi} == ($past(WDATA) & 32'h0000_03FF))
    else $error("upper code not written");
  thr_hold_a: assert property (
    !(WR && (ADDR == hds_pkg::A_THR_LO || ADDR == hds_pkg::A_THR_HI)) |=> $stable(THR_CODE))
    else $error("threshold changed without write");
  thr_read_a: assert property (
    RD && ADDR == hds_pkg::A_THR_HI |=> RDATA == {22'h0, hi_q})
    else $error("upper code readback wrong");
  do_read_a: assert property (
    RD && ADDR == hds_pkg::A_OUT_DATA |=> RDATA == {20'h0, $past(DO_ON)})
    else $error("output readback wrong");
  irq_mask_a: assert property (
    WR && ADDR == hds_pkg::A_MASK && WDATA[2:0] == 3'h0 |=> !IRQ)
    else $error("masked interrupt raised");

  cover property ($rose(IRQ));
  cover property ($changed(DO_ON));
  cover property (RD && ADDR == hds_pkg::A_IN_DATA ##1 RDATA != 32'h0000_0000);
endmodule : hds_dio_checker

bind hds_dio_top hds_dio_checker hds_dio_checker_i (.CLK(CLK), .RESET(RESET), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CMP_IN(CMP_IN), .THR_CODE(THR_CODE),
  .THR_SEL_HIGH(THR_SEL_HIGH), .DO_ON(DO_ON), .IRQ(IRQ));

// ---- sim/hds_dio_top_tb.sv ----
// Self-checking testbench for the hysteresis digital I/O block
`timescale 1ns/100ps

module hds_dio_top_tb;
  localparam int LIMIT = 6000;
  logic clk;
  logic reset;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [11:0] cmp_in;
  hds_pkg::hds_thr_t thr_code;
  logic thr_sel_high;
  logic [11:0] do_on;
  logic irq;
  logic [11:0][9:0] level;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  hds_dio_top hds_dio_top_i (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CMP_IN(cmp_in), .THR_CODE(thr_code),
    .THR_SEL_HIGH(thr_sel_high), .DO_ON(do_on), .IRQ(irq));
  hds_field_model hds_field_model_i (.thr_code(thr_code), .thr_sel_high(thr_sel_high),
    .level(level), .cmp_out(cmp_in));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Whole run needs about 1250 clocks
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      miscompares = miscompares + 1;
      tally_and_finish();
    end
  end

  // ------
  // Bus and compare tasks
  // ------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(rdata, exp);
  endtask : rd_chk

  task automatic wait_do(input logic [11:0] exp, output int n);
    n = 0;
    while (do_on !== exp && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp({20'h0, do_on}, {20'h0, exp});
  endtask : wait_do

  task automatic set_level(input logic [11:0][9:0] v);
    @(posedge clk);
    level <= v;
    repeat (60) @(posedge clk);
  endtask : set_level

  // ------
  // Scenarios
  // ------
  task automatic t_reset;
    rd_chk(hds_pkg::A_THR_LO, 32'h0000_0000);
    rd_chk(hds_pkg::A_THR_HI, 32'h0000_012C);
    rd_chk(hds_pkg::A_IN_STATE, 32'h0000_0000);
    rd_chk(hds_pkg::A_OUT_DATA, 32'h0000_0000);
    cmp({19'h0, irq, do_on}, 32'h0000_0000);
  endtask : t_reset

  task automatic t_thresh;
    // upper kept at least fifty above lower
    wr_reg(hds_pkg::A_THR_LO, 32'h0000_0064);
    wr_reg(hds_pkg::A_THR_HI, 32'h0000_03FF);
    rd_chk(hds_pkg::A_THR_HI, 32'h0000_03FF);
    cmp({12'h0, thr_code}, 32'h000F_FC64);
    wr_reg(hds_pkg::A_THR_HI, 32'h0000_0190);
  endtask : t_thresh

  task automatic t_hyst;
    // Line 1 sits between the codes and must not follow either capture
    set_level({{10{10'h032}}, 10'h0FA, 10'h1F4});
    rd_chk(hds_pkg::A_IN_STATE, 32'h0000_0001);
    rd_chk(hds_pkg::A_STATUS, 32'h0000_0001);
    wr_reg(hds_pkg::A_MASK, 32'h0000_0001);
    #1;
    cmp({31'h0, irq}, 32'h0000_0001);
    wr_reg(hds_pkg::A_STATUS, 32'h0000_0001);
    #1;
    cmp({31'h0, irq}, 32'h0000_0000);
    wr_reg(hds_pkg::A_MASK, 32'h0000_0000);
    set_level({{10{10'h032}}, 10'h1F4, 10'h0FA});
    rd_chk(hds_pkg::A_IN_STATE, 32'h0000_0003);
    set_level({{11{10'h1F4}}, 10'h032});
    rd_chk(hds_pkg::A_IN_STATE, 32'h0000_0FFE);
  endtask : t_hyst

  task automatic t_outq;
    int n;
    wr_reg(hds_pkg::A_OUT_DATA, 32'h0000_0A5C);
    wr_reg(hds_pkg::A_OUT_DATA, 32'h0000_05A3);
    wr_reg(hds_pkg::A_OUT_DATA, 32'h0000_0FFF);
    rd_chk(hds_pkg::A_LEVEL, 32'h0003_0000);
    wr_reg(hds_pkg::A_CTRL, 32'h0000_0002);
    wait_do(12'hA5C, n);
    wait_do(12'h5A3, n);
    cmp(32'(n), 32'd200);
    wait_do(12'hFFF, n);
    cmp(32'(n), 32'd200);
    rd_chk(hds_pkg::A_OUT_DATA, 32'h0000_0FFF);
    rd_chk(hds_pkg::A_LEVEL, 32'h0000_0000);
    wr_reg(hds_pkg::A_CTRL, 32'h0000_0000);
  endtask : t_outq

  task automatic t_inq;
    logic [31:0] d;
    int k;
    wr_reg(hds_pkg::A_CTRL, 32'h0000_0001);
    repeat (410) @(posedge clk);
    wr_reg(hds_pkg::A_CTRL, 32'h0000_0000);
    @(posedge clk);
    addr <= hds_pkg::A_LEVEL;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    k = int'(d[9:0]);
    // Window of 410 clocks holds two or three ticks
    cmp({31'h0, d[9:0] inside {10'd2, 10'd3}}, 32'h0000_0001);
    for (int i = 0; i < k && i < 4; i++)
    begin
      rd_chk(hds_pkg::A_IN_DATA, 32'h0000_0FFE);
    end
    rd_chk(hds_pkg::A_LEVEL, 32'h0000_0000);
    rd_chk(hds_pkg::A_IN_DATA, 32'h0000_0000);
  endtask : t_inq

  task automatic t_unmapped;
    wr_reg(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0000_0000);
    rd_chk(hds_pkg::A_THR_LO, 32'h0000_0064);
  endtask : t_unmapped

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial
  begin
    reset = 1'b1;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    level = '0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_thresh();
    t_hyst();
    t_outq();
    t_inq();
    t_unmapped();
    tally_and_finish();
  end
endmodule : hds_dio_top_tb
